/* File: design/uart_modem_pkg.sv */
// Constants, addresses and carrier types for the UART modem-status logic.
// Assumes a 32-bit Avalon-MM byte address space and active-low modem pins.
package uart_modem_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] MODEM_LINE_STATUS_ADDR = 32'hb0002018;
    localparam logic [31:0] MODEM_CONTROL_ADDR     = 32'hb0002010;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int unsigned LINES_LSB    = 4;
    localparam int unsigned FLAGS_LSB    = 0;
    localparam int unsigned LINE_COUNT   = 4;
    localparam int unsigned CONTROL_BITS = 5;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam logic [4:0]  CONTROL_RESET = 5'h00;
    localparam logic [3:0]  PINS_IDLE     = 4'hf;
    localparam logic [3:0]  LINES_RESET   = 4'h0;
    localparam logic [3:0]  FLAGS_RESET   = 4'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic carrier_in_n;
        logic bell_in_n;
        logic set_ready_in_n;
        logic send_permit_in_n;
    } modem_pins_t;

    typedef struct packed {
        logic carrier;
        logic bell_status;
        logic set_ready;
        logic send_permit;
    } modem_lines_t;

    typedef struct packed {
        logic carrier_change_flag;
        logic bell_release_flag;
        logic set_ready_change_flag;
        logic send_permit_change_flag;
    } modem_flags_t;

    typedef struct packed {
        logic loopback;
        logic aux_output_b;
        logic aux_output_a;
        logic send_request;
        logic terminal_ready;
    } modem_control_reg_t;

endpackage : uart_modem_pkg

/* File: design/uart_modem_status_logic.sv */
// Modem-status section of a UART: pin synchroniser, line levels, change
// flags and an Avalon-MM slave for the status and control registers.
// Assumes the pins are asynchronous to mclk and the master follows
// Avalon-MM waitrequest signalling.
//
// The Avalon-MM slave port was left to the implementer.
module uart_modem_status_logic (
    input  wire logic                               mclk,
    input  wire logic                               rst_b,
    input  wire logic [31:0]                        address,
    input  wire logic                               read,
    input  wire logic                               write,
    input  wire logic [31:0]                        writedata,
    input  wire logic [3:0]                         byteenable,
    output logic      [31:0]                        readdata,
    output logic                                    waitrequest,
    input  wire uart_modem_pkg::modem_pins_t        modem_pins,
    output uart_modem_pkg::modem_control_reg_t      modem_control
);

    // ------------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------------
    function automatic logic [31:0] status_word(
        input uart_modem_pkg::modem_lines_t lvl,
        input uart_modem_pkg::modem_flags_t flg
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        w[uart_modem_pkg::LINES_LSB +: uart_modem_pkg::LINE_COUNT] = lvl;
        w[uart_modem_pkg::FLAGS_LSB +: uart_modem_pkg::LINE_COUNT] = flg;
        return w;
    endfunction : status_word

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    uart_modem_pkg::modem_pins_t   pin_meta;
    uart_modem_pkg::modem_pins_t   pin_sync;
    uart_modem_pkg::modem_lines_t  prev_lines;
    uart_modem_pkg::modem_flags_t  flags;
    logic                          was_status_read;

    wire uart_modem_pkg::modem_lines_t  pin_lines;
    wire uart_modem_pkg::modem_lines_t  loop_lines;
    wire uart_modem_pkg::modem_lines_t  lines;
    wire uart_modem_pkg::modem_flags_t  events;
    wire uart_modem_pkg::modem_flags_t  next_flags;
    wire uart_modem_pkg::modem_control_reg_t next_control;
    wire logic [31:0]                   next_readdata;
    wire logic                          next_waitrequest;
    wire logic                          hit_status;
    wire logic                          hit_control;
    wire logic                          take;
    wire logic                          status_read;
    wire logic                          control_write;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Reset to idle (deasserted) so a carrier, set-ready or send-permit line held
    // asserted through reset shows up as a change right after release.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_meta <= uart_modem_pkg::modem_pins_t'(uart_modem_pkg::PINS_IDLE);
            pin_sync <= uart_modem_pkg::modem_pins_t'(uart_modem_pkg::PINS_IDLE);
        end else begin
            pin_meta <= modem_pins;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // Line levels
    // ------------------------------------------------------------------
    assign pin_lines = uart_modem_pkg::modem_lines_t'(~pin_sync);

    assign loop_lines.carrier     = modem_control.aux_output_b;
    assign loop_lines.bell_status = modem_control.aux_output_a;
    assign loop_lines.set_ready   = modem_control.terminal_ready;
    assign loop_lines.send_permit = modem_control.send_request;

    assign lines = modem_control.loopback ? loop_lines : pin_lines;

    // ------------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------------
    // Levels are compared to the level one cycle earlier, so in loopback
    // the flags follow the control bits just as they follow the pins.
    assign events.carrier_change_flag     = lines.carrier ^ prev_lines.carrier;
    assign events.bell_release_flag       = prev_lines.bell_status & ~lines.bell_status;
    assign events.set_ready_change_flag   = lines.set_ready ^ prev_lines.set_ready;
    assign events.send_permit_change_flag = lines.send_permit ^ prev_lines.send_permit;

    // A fresh event wins over the clear of a status read.
    assign next_flags = uart_modem_pkg::modem_flags_t'(
        (status_read ? uart_modem_pkg::FLAGS_RESET : flags) | events);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prev_lines <= uart_modem_pkg::modem_lines_t'(uart_modem_pkg::LINES_RESET);
            flags      <= uart_modem_pkg::modem_flags_t'(uart_modem_pkg::FLAGS_RESET);
        end else begin
            prev_lines <= lines;
            flags      <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    // Each access is answered one cycle after it is seen: waitrequest
    // drops for exactly one cycle, and the data is captured then.
    assign hit_status       = address == uart_modem_pkg::MODEM_LINE_STATUS_ADDR;
    assign hit_control      = address == uart_modem_pkg::MODEM_CONTROL_ADDR;
    assign take             = (read | write) & waitrequest;
    assign status_read      = take & read & hit_status;
    assign control_write    = take & write & hit_control & byteenable[0];
    assign next_waitrequest = ~take;

    assign next_control = control_write ?
        uart_modem_pkg::modem_control_reg_t'(writedata[uart_modem_pkg::CONTROL_BITS-1:0]) :
        modem_control;

    // Unmapped addresses read as zero; reads outside a transfer hold.
    assign next_readdata = !(take & read) ? readdata :
                           hit_status     ? status_word(lines, flags) :
                           hit_control    ? {27'h0000000, modem_control} :
                                            32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            waitrequest     <= 1'b1;
            readdata        <= uart_modem_pkg::STATUS_RESET;
            modem_control   <= uart_modem_pkg::modem_control_reg_t'(
                                   uart_modem_pkg::CONTROL_RESET);
            was_status_read <= 1'b0;
        end else begin
            waitrequest     <= next_waitrequest;
            readdata        <= next_readdata;
            modem_control   <= next_control;
            was_status_read <= status_read;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence status_capture;
        read && waitrequest && hit_status;
    endsequence

    sequence status_answer;
        $fell(waitrequest) && was_status_read;
    endsequence

    chk_reserved_zero: assert property (
        status_answer |-> readdata[31:8] == 24'h000000)
        else $error("reserved status bits not zero");

    chk_pin_read: assert property (
        status_answer ##0 (!$past(modem_control.loopback)) ##0 $past(rst_b, 3)
        |-> readdata[7:4] == ~$past(modem_pins, 3))
        else $error("status levels do not match inverted pins");

    chk_loop_read: assert property (
        status_answer ##0 $past(modem_control.loopback)
        |-> readdata[7:4] == {$past(modem_control.aux_output_b),
                              $past(modem_control.aux_output_a),
                              $past(modem_control.terminal_ready),
                              $past(modem_control.send_request)})
        else $error("loopback levels do not follow control bits");

    chk_sync_depth: assert property (
        !modem_control.loopback && $past(rst_b, 2) && $stable(modem_pins)[*3]
        ##1 !modem_control.loopback
        |-> lines == uart_modem_pkg::modem_lines_t'(~$past(modem_pins, 2)))
        else $error("pins not seen after two synchroniser stages");

    chk_carrier_change: assert property (
        (lines.carrier != prev_lines.carrier) |=> flags.carrier_change_flag)
        else $error("carrier change flag missed");

    chk_ready_change: assert property (
        (lines.set_ready != prev_lines.set_ready) |=> flags.set_ready_change_flag)
        else $error("set ready change flag missed");

    chk_permit_change: assert property (
        (lines.send_permit != prev_lines.send_permit) |=> flags.send_permit_change_flag)
        else $error("send permit change flag missed");

    chk_bell_release: assert property (
        (prev_lines.bell_status && !lines.bell_status) |=> flags.bell_release_flag)
        else $error("bell release flag missed");

    chk_bell_rising: assert property (
        !flags.bell_release_flag && !(prev_lines.bell_status && !lines.bell_status)
        |=> !flags.bell_release_flag)
        else $error("bell flag set without a release");

    chk_read_clear: assert property (
        status_capture ##0 (lines == prev_lines) |=> (flags == 4'h0) && !waitrequest)
        else $error("status read did not clear change flags");

    chk_read_return: assert property (
        status_capture ##0 (flags == 4'hf) |=> readdata[3:0] == 4'hf)
        else $error("flags cleared before being returned");

    chk_set_wins: assert property (
        status_capture ##0 (lines.carrier != prev_lines.carrier)
        |=> flags.carrier_change_flag)
        else $error("change lost in clearing read");

    chk_reset_carrier: assert property (
        $rose(rst_b) ##0 (!modem_pins.carrier_in_n && !modem_control.loopback)[*2]
        |-> ##[1:3] flags.carrier_change_flag)
        else $error("carrier held through reset not flagged");

    chk_reset_ready: assert property (
        $rose(rst_b) ##0 (!modem_pins.set_ready_in_n && !modem_control.loopback)[*2]
        |-> ##[1:3] flags.set_ready_change_flag)
        else $error("set ready held through reset not flagged");

    chk_reset_permit: assert property (
        $rose(rst_b) ##0 (!modem_pins.send_permit_in_n && !modem_control.loopback)[*2]
        |-> ##[1:3] flags.send_permit_change_flag)
        else $error("send permit held through reset not flagged");

    chk_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle wide");

    chk_ctrl_write: assert property (
        write && waitrequest && hit_control && byteenable[0]
        |=> modem_control == $past(writedata[4:0]))
        else $error("control write not stored");

    // ------------------------------------------------------------------
    // Loopback, hold and bus checks
    // ------------------------------------------------------------------
    // Loopback changes are judged only while loopback stood in both
    // cycles: entering or leaving it may move a level either way.
    sequence loop_steady;
        modem_control.loopback && $past(modem_control.loopback);
    endsequence

    chk_loop_carrier: assert property (
        loop_steady ##0 $changed(modem_control.aux_output_b) |=> flags.carrier_change_flag)
        else $error("loopback carrier change not flagged");

    chk_loop_bell: assert property (
        loop_steady ##0 $fell(modem_control.aux_output_a) |=> flags.bell_release_flag)
        else $error("loopback bell release not flagged");

    chk_loop_ready: assert property (
        loop_steady ##0 $changed(modem_control.terminal_ready)
        |=> flags.set_ready_change_flag)
        else $error("loopback set ready change not flagged");

    chk_loop_permit: assert property (
        loop_steady ##0 $changed(modem_control.send_request)
        |=> flags.send_permit_change_flag)
        else $error("loopback send permit change not flagged");

    // A flag, once set, stays until a status read takes it.
    chk_carrier_hold: assert property (
        flags.carrier_change_flag && !status_read |=> flags.carrier_change_flag)
        else $error("carrier change flag dropped without a read");

    chk_bell_hold: assert property (
        flags.bell_release_flag && !status_read |=> flags.bell_release_flag)
        else $error("bell release flag dropped without a read");

    chk_ready_hold: assert property (
        flags.set_ready_change_flag && !status_read |=> flags.set_ready_change_flag)
        else $error("set ready change flag dropped without a read");

    chk_permit_hold: assert property (
        flags.send_permit_change_flag && !status_read |=> flags.send_permit_change_flag)
        else $error("send permit change flag dropped without a read");

    // No flag sets unless its line moved.
    chk_carrier_quiet: assert property (
        !flags.carrier_change_flag && (lines.carrier == prev_lines.carrier)
        |=> !flags.carrier_change_flag)
        else $error("carrier change flag set without a change");

    chk_ready_quiet: assert property (
        !flags.set_ready_change_flag && (lines.set_ready == prev_lines.set_ready)
        |=> !flags.set_ready_change_flag)
        else $error("set ready change flag set without a change");

    chk_permit_quiet: assert property (
        !flags.send_permit_change_flag && (lines.send_permit == prev_lines.send_permit)
        |=> !flags.send_permit_change_flag)
        else $error("send permit change flag set without a change");

    // A change in the very cycle of a clearing read survives it.
    chk_ready_kept: assert property (
        status_capture ##0 (lines.set_ready != prev_lines.set_ready)
        |=> flags.set_ready_change_flag)
        else $error("set ready change lost in clearing read");

    chk_permit_kept: assert property (
        status_capture ##0 (lines.send_permit != prev_lines.send_permit)
        |=> flags.send_permit_change_flag)
        else $error("send permit change lost in clearing read");

    chk_flags_return: assert property (
        status_capture |=> readdata[3:0] == $past(flags))
        else $error("status read returned wrong change flags");

    chk_lines_return: assert property (
        status_capture |=> readdata[7:4] == $past(lines))
        else $error("status read returned wrong line levels");

    chk_reset_state: assert property (
        $rose(rst_b) |-> (pin_sync == 4'hf) && (prev_lines == 4'h0) && (flags == 4'h0))
        else $error("change detector not idle after reset");

    // Bus answers: one low cycle per access, nothing without a request.
    chk_idle_wait: assert property (
        !(read || write) && waitrequest |=> waitrequest)
        else $error("waitrequest dropped with no request");

    chk_answer_once: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    chk_unmapped_read: assert property (
        take && read && !hit_status && !hit_control |=> readdata == 32'h0000_0000)
        else $error("unmapped address did not read zero");

    chk_ctrl_read: assert property (
        take && read && hit_control
        |=> readdata == {27'h0000000, $past(modem_control)})
        else $error("control register read back wrong");

    chk_ctrl_hold: assert property (
        !control_write |=> $stable(modem_control))
        else $error("control register changed without a write");

    chk_status_unwritten: assert property (
        take && write && hit_status |=> readdata == $past(readdata))
        else $error("status write disturbed read data");

    chk_read_stands: assert property (
        !(take && read) |=> $stable(readdata))
        else $error("read data moved without a read");

endmodule : uart_modem_status_logic

/* File: verification/modem_model.sv */
// Behavioural modem that drives the four active-low handshake pins.
// Assumes pins may move only just after a rising edge of mclk.
module modem_model (
    input  wire logic                        mclk,
    input  wire uart_modem_pkg::modem_pins_t want,
    input  wire logic [3:0]                  lag,
    output uart_modem_pkg::modem_pins_t      modem_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    initial begin
        modem_pins = uart_modem_pkg::PINS_IDLE;
        wait_cnt = 4'h0;
    end
    // A slow modem lets a requested level wait lag cycles
    always @(posedge mclk) begin
        if (modem_pins !== want && wait_cnt >= lag) begin
            modem_pins <= want;
            wait_cnt <= 4'h0;
        end else if (modem_pins !== want) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : modem_model

/* File: verification/uart_modem_status_logic_tb_top.sv */
// Self-checking bench for the modem-status logic.
// Assumes the Avalon slave answers with waitrequest low and pins are async.
module uart_modem_status_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] STA = uart_modem_pkg::MODEM_LINE_STATUS_ADDR;
    localparam logic [31:0] CTL = uart_modem_pkg::MODEM_CONTROL_ADDR;
    logic mclk, rst_b, read, write, waitrequest;
    logic [31:0] address, writedata, readdata, rd1, rd2;
    logic [3:0] byteenable, lag;
    uart_modem_pkg::modem_pins_t want, modem_pins;
    uart_modem_pkg::modem_control_reg_t modem_control;
    int n_errors = 0;
    int cmp_count = 0;
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    uart_modem_status_logic u_uart_modem_status_logic (.mclk(mclk), .rst_b(rst_b),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .modem_pins(modem_pins), .modem_control(modem_control));
    modem_model u_modem_model (.mclk(mclk), .want(want), .lag(lag), .modem_pins(modem_pins));
    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
             input logic [3:0] be, output logic [31:0] q);
        @(posedge mclk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        do begin
            @(posedge mclk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        check(q, exp);
    endtask : rd_chk
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask : wr
    task set_pins(input logic [3:0] v);
        want <= v;
        repeat (int'(lag) + 6) @(posedge mclk);
    endtask : set_pins
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task test_reset_hold;
        repeat (4) @(posedge mclk);
        rd_chk(STA, 32'h0000_00bb);
        rd_chk(STA, 32'h0000_00b0);
        $display("test reset_hold done");
    endtask : test_reset_hold
    task test_each_line;
        logic [31:0] e;
        lag = 4'h2;
        set_pins(4'hf);
        rd_chk(STA, 32'h0000_000b);
        for (int i = 0; i < 4; i++) begin
            e = (32'h1 << (4 + i)) | ((i == 2) ? 32'h0 : (32'h1 << i));
            set_pins(4'hf & ~(4'h1 << i));
            rd_chk(STA, e);
            set_pins(4'hf);
            rd_chk(STA, 32'h1 << i);
        end
        lag = 4'h0;
        $display("test each_line done");
    endtask : test_each_line
    task test_loopback;
        wr(CTL, 32'h0000_0010, 4'h1);
        check({27'h0, modem_control}, 32'h0000_0010);
        rd_chk(STA, 32'h0000_0000);
        set_pins(4'h0);
        wr(CTL, 32'h0000_001f, 4'h1);
        rd_chk(STA, 32'h0000_00fb);
        rd_chk(STA, 32'h0000_00f0);
        wr(CTL, 32'h0000_0010, 4'h1);
        rd_chk(STA, 32'h0000_000f);
        rd_chk(CTL, 32'h0000_0010);
        wr(CTL, 32'h0000_0000, 4'h1);
        repeat (4) @(posedge mclk);
        rd_chk(STA, 32'h0000_00fb);
        set_pins(4'hf);
        rd_chk(STA, 32'h0000_000f);
        $display("test loopback done");
    endtask : test_loopback
    task test_refusals;
        rd_chk(32'hb000_201c, 32'h0000_0000);
        wr(STA, 32'hffff_ffff, 4'hf);
        rd_chk(STA, 32'h0000_0000);
        wr(CTL, 32'h0000_001f, 4'he);
        rd_chk(CTL, 32'h0000_0000);
        check({27'h0, modem_control}, 32'h0000_0000);
        $display("test refusals done");
    endtask : test_refusals
    task test_read_race;
        want <= 4'h4;
        repeat (2) @(posedge mclk);
        bus(1'b0, STA, 32'h0, 4'hf, rd1);
        bus(1'b0, STA, 32'h0, 4'hf, rd2);
        check((rd1 | rd2) & 32'hf, 32'h0000_000b);
        check(rd2 & 32'hf0, 32'h0000_00b0);
        $display("test read_race done");
    endtask : test_read_race
    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        #(25ns * 20000);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 32'h0;
        writedata = 32'h0;
        byteenable = 4'h0;
        lag = 4'h0;
        want = 4'h4;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        test_reset_hold();
        test_each_line();
        test_loopback();
        test_refusals();
        test_read_race();
        stop_test();
    end
endmodule : uart_modem_status_logic_tb_top
